// *** hdl/dci_cmd_decode.sv ***
// command decoder from pin levels and two clock-enable samples
// assumes pins are sampled on the same edge as cke_now
`timescale 1ns/100ps
module dci_cmd_decode (
  input wire logic cke_prev,
  input wire logic cke_now,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  output dci_pkg::dci_cmd_e cmd
);
  logic quiet;

  // RULE5 deselect or nop
  assign quiet = cs_n | (ras_n & cas_n & we_n);

  // RULE7 two cke samples
  always_comb begin
    cmd = dci_pkg::CMD_NOP;
    if (!cke_prev) begin
      // RULE6 exit on rising cke
      if (cke_now && quiet) begin
        cmd = dci_pkg::CMD_WAKE;
      end
    end else if (!cke_now) begin
      if (quiet) begin
        cmd = dci_pkg::CMD_PDE;
      end else if (!ras_n && !cas_n && we_n) begin
        cmd = dci_pkg::CMD_SRE;
      end else begin
        cmd = dci_pkg::CMD_ILL;
      end
    end else if (!cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: cmd = dci_pkg::CMD_NOP;
        3'h3: cmd = dci_pkg::CMD_ACT;
        // RULE21 precharge coding
        3'h2: cmd = a10 ? dci_pkg::CMD_PREA : dci_pkg::CMD_PRE;
        3'h5: cmd = dci_pkg::CMD_RD;
        3'h4: cmd = dci_pkg::CMD_WR;
        // RULE4 all strobes low
        3'h0: cmd = dci_pkg::CMD_MRS;
        3'h1: cmd = dci_pkg::CMD_REF;
        3'h6: cmd = dci_pkg::CMD_BST;
      endcase
    end
  end
endmodule : dci_cmd_decode

// *** hdl/dci_ctrl.sv ***
// controller end: power-up sequence, then one request at a time
// assumes the user keeps banks legal and times write data to bursts
//
// Notes on behaviour
// RULE1 - activate carries bank and full row
// RULE2 - column from low bits, A10 auto-precharge
// RULE3 - activate idle banks, access active banks
// RULE4 - mode writes all strobes low, idle only
// RULE5 - power-down entry from idle, cke falling
// RULE6 - power-down exit on cke rising
// RULE7 - device uses two cke samples
// RULE8 - masked write beats are not stored
// RULE9 - byte masks act independently
// RULE10 - bursts of four or eight in sequence
// RULE11 - hold cke and odt low at power
// RULE12 - wait 200 us, then raise cke
// RULE13 - 400 ns of nop, then precharge all
// RULE14 - write extended two, then extended three
// RULE15 - extended one with DLL enabled
// RULE16 - base mode register with DLL reset
// RULE17 - precharge all, then two refreshes
// RULE18 - base mode register without DLL reset
// RULE19 - calibration at least 200 clocks later
// RULE20 - calibration default, then calibration exit
// RULE21 - precharge coding returns bank to idle
// RULE22 - mode write cycle time before next
// RULE23 - nop between sequence commands
`timescale 1ns/100ps
module dci_ctrl #(
  parameter int PWRUP = dci_pkg::PWRUP_CYC,
  parameter int REF_GAP = 16,
  parameter logic [12:0] MR_OPS = 13'h0032,
  parameter logic [12:0] EMR1_OPS = 13'h0000
) (
  input wire logic ref_clk,
  input wire logic rst,
  dci_if.ctl link,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [1:0] req_bank,
  input wire logic [dci_pkg::AW-1:0] req_addr,
  output logic req_ready,
  input wire logic [dci_pkg::DW-1:0] wr_data,
  input wire logic [1:0] wr_mask,
  output logic [dci_pkg::DW-1:0] rd_data,
  output logic rd_valid,
  input wire logic pd_req,
  output logic in_pd,
  output logic init_done
);
  typedef enum logic [3:0] {
    S_PWR = 4'h0, S_CKE = 4'h1, S_EMR2 = 4'h2, S_EMR3 = 4'h3,
    S_EMR1 = 4'h4, S_MRRST = 4'h5, S_PREA2 = 4'h6, S_REF = 4'h7,
    S_MR = 4'h8, S_OCDD = 4'h9, S_OCDX = 4'ha, S_IDLE = 4'hb,
    S_PD = 4'hc
  } dci_state_e;

  localparam logic [15:0] GAP = 16'(dci_pkg::MRD_CYC - 1);
  localparam logic [7:0] LOCK = 8'(dci_pkg::DLL_LOCK_CYC);
  localparam logic [15:0] BURST_GAP =
    (MR_OPS[2:0] == dci_pkg::BL8) ? 16'h0008 : 16'h0004;

  dci_state_e state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [1:0] ref_reg, ref_next;
  logic [7:0] dll_reg;
  logic cke_reg, cke_next;
  dci_pkg::dci_cmd_e cmd_next;
  logic [1:0] ba_reg, ba_next;
  logic [dci_pkg::AW-1:0] addr_reg, addr_next;
  logic [3:0] pins_reg;
  logic [dci_pkg::DW-1:0] wdata_reg;
  logic [1:0] dm_reg;
  logic take;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ref_next = ref_reg;
    cke_next = cke_reg;
    // RULE23 nop unless a command
    cmd_next = dci_pkg::CMD_NOP;
    ba_next = 2'h0;
    addr_next = '0;
    take = 1'b0;
    if (cnt_reg != '0) begin
      // RULE22 spacing after each command
      cnt_next = cnt_reg - 16'h0001;
    end else begin
      unique case (state_reg)
        // RULE12 cke up after the wait
        S_PWR: begin
          cke_next = 1'b1;
          cnt_next = 16'(dci_pkg::CKE_CYC);
          state_next = S_CKE;
        end
        // RULE13 precharge all after 400 ns
        S_CKE: begin
          cmd_next = dci_pkg::CMD_PREA;
          addr_next[dci_pkg::AP_BIT] = 1'b1;
          cnt_next = GAP;
          state_next = S_EMR2;
        end
        // RULE14 extended two then three
        S_EMR2: begin
          cmd_next = dci_pkg::CMD_MRS;
          ba_next = dci_pkg::BA_EMR2;
          cnt_next = GAP;
          state_next = S_EMR3;
        end
        S_EMR3: begin
          cmd_next = dci_pkg::CMD_MRS;
          ba_next = dci_pkg::BA_EMR3;
          cnt_next = GAP;
          state_next = S_EMR1;
        end
        // RULE15 DLL enable
        S_EMR1: begin
          cmd_next = dci_pkg::CMD_MRS;
          ba_next = dci_pkg::BA_EMR1;
          addr_next = EMR1_OPS;
          addr_next[dci_pkg::DLL_DIS_BIT] = 1'b0;
          cnt_next = GAP;
          state_next = S_MRRST;
        end
        // RULE16 DLL reset
        S_MRRST: begin
          cmd_next = dci_pkg::CMD_MRS;
          ba_next = dci_pkg::BA_MR;
          addr_next = MR_OPS;
          addr_next[dci_pkg::DLL_RST_BIT] = 1'b1;
          cnt_next = GAP;
          state_next = S_PREA2;
        end
        // RULE17 precharge all, refreshes
        S_PREA2: begin
          cmd_next = dci_pkg::CMD_PREA;
          addr_next[dci_pkg::AP_BIT] = 1'b1;
          cnt_next = GAP;
          ref_next = 2'h0;
          state_next = S_REF;
        end
        S_REF: begin
          cmd_next = dci_pkg::CMD_REF;
          cnt_next = 16'(REF_GAP - 1);
          ref_next = ref_reg + 2'h1;
          if (ref_reg == 2'(dci_pkg::REF_MIN - 1)) begin
            state_next = S_MR;
          end
        end
        // RULE18 operating mode, no DLL reset
        S_MR: begin
          cmd_next = dci_pkg::CMD_MRS;
          ba_next = dci_pkg::BA_MR;
          addr_next = MR_OPS;
          addr_next[dci_pkg::DLL_RST_BIT] = 1'b0;
          cnt_next = GAP;
          state_next = S_OCDD;
        end
        // RULE19 wait for DLL lock
        S_OCDD: begin
          if (dll_reg == LOCK) begin
            // RULE20 calibration default
            cmd_next = dci_pkg::CMD_MRS;
            ba_next = dci_pkg::BA_EMR1;
            addr_next = EMR1_OPS;
            addr_next[dci_pkg::DLL_DIS_BIT] = 1'b0;
            addr_next[dci_pkg::OCD_LSB+:3] = dci_pkg::OCD_DFLT;
            cnt_next = GAP;
            state_next = S_OCDX;
          end
        end
        // RULE20 calibration exit
        S_OCDX: begin
          cmd_next = dci_pkg::CMD_MRS;
          ba_next = dci_pkg::BA_EMR1;
          addr_next = EMR1_OPS;
          addr_next[dci_pkg::DLL_DIS_BIT] = 1'b0;
          addr_next[dci_pkg::OCD_LSB+:3] = dci_pkg::OCD_EXIT;
          cnt_next = GAP;
          state_next = S_IDLE;
        end
        S_IDLE: begin
          if (req_valid && req_ready) begin
            take = 1'b1;
            ba_next = req_bank;
            addr_next = req_addr;
            cnt_next = GAP;
            unique case (req_op)
              // RULE1 bank and row
              2'h0: cmd_next = dci_pkg::CMD_ACT;
              // RULE2 column with A10 flag
              2'h1: cmd_next = dci_pkg::CMD_RD;
              2'h2: cmd_next = dci_pkg::CMD_WR;
              2'h3: cmd_next = dci_pkg::CMD_PRE;
            endcase
            if (req_op == 2'h1 || req_op == 2'h2) begin
              cnt_next = BURST_GAP;
            end
          end else if (pd_req) begin
            // RULE5 cke falls with nop
            cke_next = 1'b0;
            state_next = S_PD;
          end
        end
        S_PD: begin
          if (!pd_req) begin
            // RULE6 cke rises with nop
            cke_next = 1'b1;
            cnt_next = GAP;
            state_next = S_IDLE;
          end
        end
        default: state_next = S_PWR;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // RULE11 cke low while powering
      state_reg <= S_PWR;
      cnt_reg <= 16'(PWRUP - 1);
      ref_reg <= 2'h0;
      cke_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ref_reg <= ref_next;
      cke_reg <= cke_next;
    end
  end

  // RULE19 clocks since DLL reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dll_reg <= 8'h00;
    end else if (state_reg == S_MRRST && cnt_reg == '0) begin
      dll_reg <= 8'h01;
    end else if (dll_reg != 8'h00 && dll_reg != LOCK) begin
      dll_reg <= dll_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // link and user outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pins_reg <= 4'hf;
      ba_reg <= 2'h0;
      addr_reg <= '0;
      wdata_reg <= '0;
      dm_reg <= 2'h3;
      req_ready <= 1'b0;
      in_pd <= 1'b0;
      init_done <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      pins_reg <= dci_pkg::cmd_pins(cmd_next);
      ba_reg <= ba_next;
      addr_reg <= addr_next;
      wdata_reg <= wr_data;
      dm_reg <= wr_mask;
      req_ready <= state_next == S_IDLE && cnt_next == '0 && !take;
      in_pd <= state_next == S_PD;
      init_done <= state_next == S_IDLE || state_next == S_PD;
      rd_data <= link.rdata;
      rd_valid <= link.rvalid;
    end
  end

  assign link.cke = cke_reg;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins_reg;
  assign link.ba = ba_reg;
  assign link.addr = addr_reg;
  // RULE11 termination held off
  assign link.odt = 1'b0;
  assign link.wdata = wdata_reg;
  assign link.lower_byte_write_mask = dm_reg[0];
  assign link.upper_byte_write_mask = dm_reg[1];
endmodule : dci_ctrl

// *** hdl/dci_device.sv ***
// memory device end: bank state, mode registers, bursts, masks
// assumes the controller keeps its own ordering duties
`timescale 1ns/100ps
module dci_device #(
  parameter int COL_AW = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  dci_if.dev link,
  output logic [dci_pkg::NBANK-1:0] bank_open,
  output logic power_down,
  output logic self_refresh,
  output logic dll_on,
  output logic cmd_reject,
  output logic [dci_pkg::AW-1:0] mode_word
);
  localparam int IW = 2 + COL_AW;

  dci_pkg::dci_cmd_e cmd;
  logic cke_prev_reg;
  logic busy_reg, wr_reg, ap_reg;
  logic [2:0] beat_reg;
  logic [1:0] bank_reg;
  logic [dci_pkg::COL_LSB_W-1:0] col_reg;
  logic [dci_pkg::AW-1:0] row_reg [dci_pkg::NBANK];
  logic [dci_pkg::AW-1:0] mr_reg [4];
  logic [dci_pkg::DW-1:0] mem [2**IW];
  logic [dci_pkg::DW-1:0] rdata_reg;
  logic rvalid_reg;
  logic all_idle, bl8, last, ok, bad;
  logic [IW-1:0] idx;

  dci_cmd_decode dci_cmd_decode_i (
    .cke_prev(cke_prev_reg),
    .cke_now(link.cke),
    .cs_n(link.cs_n),
    .ras_n(link.ras_n),
    .cas_n(link.cas_n),
    .we_n(link.we_n),
    .a10(link.addr[dci_pkg::AP_BIT]),
    .cmd(cmd)
  );

  // RULE7 earlier cke sample
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= link.cke;
    end
  end

  // ------------------------------------------------------------
  // acceptance
  // ------------------------------------------------------------
  assign all_idle = (bank_open == '0) && !busy_reg;
  assign bl8 = mr_reg[0][2:0] == dci_pkg::BL8;
  assign last = beat_reg == (bl8 ? 3'h7 : 3'h3);

  always_comb begin
    ok = 1'b0;
    bad = 1'b0;
    unique case (cmd)
      dci_pkg::CMD_ACT: ok = !bank_open[link.ba];
      dci_pkg::CMD_RD, dci_pkg::CMD_WR:
        ok = bank_open[link.ba] && !busy_reg;
      dci_pkg::CMD_MRS, dci_pkg::CMD_REF, dci_pkg::CMD_PDE,
      dci_pkg::CMD_SRE: ok = all_idle;
      dci_pkg::CMD_ILL: bad = 1'b1;
      default: ok = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= bad | !ok;
    end
  end

  // ------------------------------------------------------------
  // banks
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_open <= '0;
    end else begin
      // RULE2 auto-precharge at burst end
      if (busy_reg && last && ap_reg) begin
        bank_open[bank_reg] <= 1'b0;
      end
      // RULE1 open addressed row
      if (cmd == dci_pkg::CMD_ACT && ok) begin
        bank_open[link.ba] <= 1'b1;
      end
      // RULE21 bank back to idle
      if (cmd == dci_pkg::CMD_PRE) begin
        bank_open[link.ba] <= 1'b0;
      end else if (cmd == dci_pkg::CMD_PREA) begin
        bank_open <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cmd == dci_pkg::CMD_ACT && ok) begin
      row_reg[link.ba] <= link.addr;
    end
  end

  // ------------------------------------------------------------
  // mode registers and low-power states
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        mr_reg[i] <= dci_pkg::MR_RST;
      end
      dll_on <= 1'b0;
    end else if (cmd == dci_pkg::CMD_MRS && ok) begin
      // RULE4 bank inputs pick register
      mr_reg[link.ba] <= link.addr;
      if (link.ba == dci_pkg::BA_EMR1) begin
        dll_on <= !link.addr[dci_pkg::DLL_DIS_BIT];
      end
    end
  end

  assign mode_word = mr_reg[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_down <= 1'b0;
      self_refresh <= 1'b0;
    end else if (cmd == dci_pkg::CMD_WAKE) begin
      // RULE6 leave from any state
      power_down <= 1'b0;
      self_refresh <= 1'b0;
    end else if (cmd == dci_pkg::CMD_PDE && ok) begin
      // RULE5 enter only from idle
      power_down <= 1'b1;
    end else if (cmd == dci_pkg::CMD_SRE && ok) begin
      self_refresh <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // bursts
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      ap_reg <= 1'b0;
      beat_reg <= 3'h0;
      bank_reg <= 2'h0;
      col_reg <= '0;
    end else if ((cmd == dci_pkg::CMD_RD || cmd == dci_pkg::CMD_WR)
        && ok) begin
      // RULE2 start column and auto-precharge
      busy_reg <= 1'b1;
      wr_reg <= cmd == dci_pkg::CMD_WR;
      ap_reg <= link.addr[dci_pkg::AP_BIT];
      col_reg <= link.addr[dci_pkg::COL_LSB_W-1:0];
      bank_reg <= link.ba;
      beat_reg <= 3'h0;
    end else if (busy_reg) begin
      // RULE10 four or eight beats
      beat_reg <= beat_reg + 3'h1;
      busy_reg <= !last;
    end
  end

  // RULE10 programmed sequence
  assign idx = {bank_reg, col_reg[COL_AW-1:3],
    dci_pkg::burst_col(col_reg[2:0], beat_reg, bl8,
    mr_reg[0][dci_pkg::BT_BIT])};

  always_ff @(posedge ref_clk) begin
    if (busy_reg && wr_reg) begin
      // RULE8 masked beats not stored
      // RULE9 each mask owns one byte
      if (!link.lower_byte_write_mask) begin
        mem[idx][7:0] <= link.wdata[7:0];
      end
      if (!link.upper_byte_write_mask) begin
        mem[idx][15:8] <= link.wdata[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= mem[idx];
      rvalid_reg <= busy_reg && !wr_reg;
    end
  end

  assign link.rdata = rdata_reg;
  assign link.rvalid = rvalid_reg;
endmodule : dci_device

// *** inc/dci_if.sv ***
// pin-level link between a ddr2 controller and the memory device
// assumes both ends run on the same ref_clk
`timescale 1ns/100ps
interface dci_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic [1:0] ba;
  logic [dci_pkg::AW-1:0] addr;
  logic [dci_pkg::DW-1:0] wdata;
  logic lower_byte_write_mask;
  logic upper_byte_write_mask;
  logic [dci_pkg::DW-1:0] rdata;
  logic rvalid;

  modport ctl(output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
    wdata, lower_byte_write_mask, upper_byte_write_mask,
    input rdata, rvalid);
  modport dev(input cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
    wdata, lower_byte_write_mask, upper_byte_write_mask,
    output rdata, rvalid);
endinterface : dci_if

// *** inc/dci_pkg.sv ***
// shared constants, command codes and helpers for the ddr2 command
// decode and initialization ends; assumes a single 125 MHz clock
package dci_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int T_PWRUP_US = 200;
  localparam int PWRUP_CYC = T_PWRUP_US * CLK_MHZ;
  localparam int T_CKE_NS = 400;
  localparam int CKE_CYC = (T_CKE_NS * CLK_MHZ + 999) / 1000;
  localparam int DLL_LOCK_CYC = 200;
  localparam int MRD_CYC = 2;
  localparam int REF_MIN = 2;

  // ------------------------------------------------------------
  // widths and fields
  // ------------------------------------------------------------
  localparam int AW = 13;
  localparam int DW = 16;
  localparam int NBANK = 4;
  localparam int COL_LSB_W = 9;
  localparam int AP_BIT = 10;
  localparam int DLL_DIS_BIT = 0;
  localparam int DLL_RST_BIT = 8;
  localparam int OCD_LSB = 7;
  localparam int BT_BIT = 3;
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;
  localparam logic [1:0] BA_EMR2 = 2'h2;
  localparam logic [1:0] BA_EMR3 = 2'h3;
  localparam logic [2:0] BL4 = 3'h2;
  localparam logic [2:0] BL8 = 3'h3;
  localparam logic [2:0] OCD_DFLT = 3'h7;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [12:0] MR_RST = 13'h0000;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
    CMD_PRE = 4'h4, CMD_PREA = 4'h5, CMD_MRS = 4'h6, CMD_REF = 4'h7,
    CMD_BST = 4'h8, CMD_PDE = 4'h9, CMD_SRE = 4'ha, CMD_WAKE = 4'hb,
    CMD_ILL = 4'hc
  } dci_cmd_e;

  // {cs_n, ras_n, cas_n, we_n} for a command
  function automatic logic [3:0] cmd_pins(input dci_cmd_e c);
    unique case (c)
      CMD_ACT: cmd_pins = 4'h3;
      CMD_RD: cmd_pins = 4'h5;
      CMD_WR: cmd_pins = 4'h4;
      CMD_PRE, CMD_PREA: cmd_pins = 4'h2;
      CMD_MRS: cmd_pins = 4'h0;
      CMD_REF: cmd_pins = 4'h1;
      default: cmd_pins = 4'h7;
    endcase
  endfunction : cmd_pins

  // column low bits of beat i
  function automatic logic [2:0] burst_col(input logic [2:0] s,
      input logic [2:0] i, input logic bl8, input logic intl);
    if (intl) begin
      burst_col = s ^ i;
    end else if (bl8) begin
      burst_col = s + i;
    end else begin
      burst_col = {s[2], s[1:0] + i[1:0]};
    end
  endfunction : burst_col

endpackage : dci_pkg

// *** testbench/dci_link_checker.sv ***
// assertions on the pin link between the two ends
// assumes one clock, sync high reset, burst length four
`timescale 1ns/100ps
module dci_link_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [1:0] ba,
  input wire logic [dci_pkg::AW-1:0] addr,
  input wire logic [dci_pkg::DW-1:0] wdata,
  input wire logic lower_byte_write_mask,
  input wire logic upper_byte_write_mask,
  input wire logic [dci_pkg::DW-1:0] rdata,
  input wire logic rvalid
);
  logic nop;
  logic rd;
  logic mrs;
  logic [5:0] hi_cnt;
  logic [7:0] lock_cnt;
  logic ocd_dflt;
  assign nop = cs_n | (ras_n & cas_n & we_n);
  assign rd = cke & ~cs_n & ras_n & ~cas_n & we_n;
  assign mrs = ~cs_n & ~ras_n & ~cas_n & ~we_n;
  assign ocd_dflt = mrs && ba == dci_pkg::BA_EMR1
    && addr[dci_pkg::OCD_LSB+:3] == dci_pkg::OCD_DFLT;
  // saturates: only the first command after power-up matters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hi_cnt <= 6'h00;
    end else if (cke && hi_cnt != 6'h3f) begin
      hi_cnt <= hi_cnt + 6'h01;
    end
  end
  // clocks since the dll-reset write, held at its top
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_cnt <= 8'h00;
    end else if (mrs && ba == dci_pkg::BA_MR
        && addr[dci_pkg::DLL_RST_BIT]) begin
      lock_cnt <= 8'h01;
    end else if (lock_cnt != 8'h00 && lock_cnt != 8'hff) begin
      lock_cnt <= lock_cnt + 8'h01;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  odt_held_low_a:
    assert property (odt == 1'b0) else $error("odt driven high");
  cke_rise_nop_a:
    assert property ($rose(cke) |-> nop) else $error("cke rise with cmd");
  cke_fall_nop_a:
    assert property ($fell(cke) |-> nop) else $error("cke fall with cmd");
  mode_cke_high_a:
    assert property (mrs |-> cke && $past(cke))
      else $error("mode write with cke low");
  mode_gap_a:
    assert property (mrs |=> nop) else $error("mode write too close");
  first_cmd_wait_a:
    assert property (!nop && cke |-> hi_cnt >= 6'h32)
      else $error("command before 400 ns");
  dll_enable_a:
    assert property (mrs && ba == dci_pkg::BA_EMR1
      |-> addr[dci_pkg::DLL_DIS_BIT] == 1'b0) else $error("dll disabled");
  read_burst_a:
    assert property (rd |-> ##2 rvalid [*4] ##1 !rvalid)
      else $error("read burst length");
  read_cause_a:
    assert property ($rose(rvalid) |-> $past(rd, 2))
      else $error("read data without read");
  ocd_after_lock_a:
    assert property (ocd_dflt |-> lock_cnt >= 8'hc8)
      else $error("calibration too early");
  cover property (ocd_dflt);
  cover property (rd);
  cover property (mrs && ba == dci_pkg::BA_EMR2);
  cover property ($fell(cke));
endmodule : dci_link_checker

// *** testbench/ddr2_command_decode_and_init_bench.sv ***
// self-checking bench: controller and device joined over the link
// assumes a short power-up count; all stimulus from the user side
`timescale 1ns/100ps
module ddr2_command_decode_and_init_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] wr_mask = 2'h0;
  logic pd_req = 1'b0;
  logic req_ready, rd_valid, in_pd, init_done, power_down, dll_on;
  logic cmd_reject;
  logic [15:0] rd_data;
  logic [3:0] bank_open;
  logic [12:0] mode_word;
  logic [15:0] wd [4];
  logic [1:0] wm [4];
  logic [15:0] got [4];
  int fails = 0;
  int cmp_count = 0;
  int rej_cnt = 0;
  dci_if dci_if_i ();
  dci_ctrl #(.PWRUP(50), .REF_GAP(4), .MR_OPS(13'h0032)) dci_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .link(dci_if_i), .req_valid(req_valid),
    .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr),
    .req_ready(req_ready), .wr_data(wr_data), .wr_mask(wr_mask),
    .rd_data(rd_data), .rd_valid(rd_valid), .pd_req(pd_req),
    .in_pd(in_pd), .init_done(init_done));
  dci_device #(.COL_AW(4)) dci_device_i (.ref_clk(ref_clk), .rst(rst),
    .link(dci_if_i), .bank_open(bank_open), .power_down(power_down),
    .self_refresh(), .dll_on(dll_on), .cmd_reject(cmd_reject),
    .mode_word(mode_word));
  dci_link_checker dci_link_checker_i (.ref_clk(ref_clk), .rst(rst),
    .cke(dci_if_i.cke), .cs_n(dci_if_i.cs_n), .ras_n(dci_if_i.ras_n),
    .cas_n(dci_if_i.cas_n), .we_n(dci_if_i.we_n), .odt(dci_if_i.odt),
    .ba(dci_if_i.ba), .addr(dci_if_i.addr), .wdata(dci_if_i.wdata),
    .lower_byte_write_mask(dci_if_i.lower_byte_write_mask),
    .upper_byte_write_mask(dci_if_i.upper_byte_write_mask),
    .rdata(dci_if_i.rdata), .rvalid(dci_if_i.rvalid));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // sampled off-edge so a one-cycle pulse counts once
  always @(negedge ref_clk) begin
    if (cmd_reject === 1'b1) rej_cnt++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check
  // wait targets: 0 ready, 1 power-down, 2 init done
  function automatic logic pick(input int w);
    pick = (w == 0) ? req_ready : (w == 1) ? power_down : init_done;
  endfunction : pick
  task automatic wait_for(input int w, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pick(w) !== v && n < lim);
    if (pick(w) !== v) begin
      fails++;
      $display("Error at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask : wait_for
  // one request; write beats follow the take edge, reads are collected
  task automatic req(input logic [1:0] op, input logic [1:0] bk,
      input logic [12:0] a);
    int n;
    int k;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_bank <= bk;
    req_addr <= a;
    wait_for(0, 1'b1, 200);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    k = 0;
    if (op == 2'h1) begin
      while (k < 4 && n < 20) begin
        @(negedge ref_clk);
        n++;
        if (rd_valid === 1'b1) begin
          got[k] = rd_data;
          k++;
        end
      end
      check(k == 4, "read beats missing");
    end else begin
      for (int i = 0; i < 4; i++) begin
        wr_data <= wd[i];
        wr_mask <= wm[i];
        @(posedge ref_clk);
      end
    end
  endtask : req
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic act_twice;
    req(2'h0, 2'h1, 13'h1abc);
    check(bank_open === 4'h2, "bank not opened");
    req(2'h0, 2'h1, 13'h0155);
    check(rej_cnt == 1, "activate to open bank taken");
  endtask : act_twice
  // second write masks bytes per beat and wraps from col 7 to col 4
  task automatic mask_burst;
    wd = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    wm = '{2'h0, 2'h0, 2'h0, 2'h0};
    req(2'h2, 2'h1, 13'h0004);
    wd = '{16'haa01, 16'hbb02, 16'hcc03, 16'hdd04};
    wm = '{2'h0, 2'h1, 2'h2, 2'h3};
    req(2'h2, 2'h1, 13'h0005);
    req(2'h1, 2'h1, 13'h0404);
    check(got[0] === 16'h1111, "fully masked beat stored");
    check(got[1] === 16'haa01, "unmasked beat lost");
    check(got[2] === 16'hbb33, "lower mask wrong");
    check(got[3] === 16'h4403, "upper mask wrong");
    req(2'h0, 2'h2, 13'h0abc);
    check(bank_open === 4'h4, "auto-precharge missing");
    req(2'h3, 2'h2, 13'h0000);
    check(bank_open === 4'h0, "precharge left bank open");
    check(rej_cnt == 1, "legal command refused");
  endtask : mask_burst
  task automatic pd_cycle;
    @(posedge ref_clk);
    pd_req <= 1'b1;
    wait_for(1, 1'b1, 50);
    check(in_pd === 1'b1 && dci_if_i.cke === 1'b0, "pd entry");
    @(posedge ref_clk);
    pd_req <= 1'b0;
    wait_for(1, 1'b0, 50);
    check(in_pd === 1'b0 && dci_if_i.cke === 1'b1, "pd exit");
  endtask : pd_cycle
  initial begin
    wd = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    wm = '{2'h3, 2'h3, 2'h3, 2'h3};
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    wait_for(2, 1'b1, 2000);
    check(dll_on === 1'b1, "dll off after init");
    check(mode_word === 13'h0032, "base mode word");
    check(bank_open === 4'h0 && rej_cnt == 0, "init refused");
    act_twice();
    mask_burst();
    pd_cycle();
    tally_and_finish();
  end
endmodule : ddr2_command_decode_and_init_bench
